// ===== pkg/cfi_pkg.sv
// package for the flag and interrupt-accept block: register map, field positions, carriers
// assumes a 32-bit apb slave with word-aligned registers
package cfi_pkg;

    localparam int unsigned PRIO_W    = 3;
    localparam int unsigned VEC_W     = 6;
    localparam int unsigned BANK_REGS = 7;
    localparam int unsigned NUM_BANKS = 2;
    localparam int unsigned ADDR_W    = 12;

    // byte addresses
    localparam logic [11:0] FLAGS_OFFSET     = 12'h000;
    localparam logic [11:0] ISP_OFFSET       = 12'h004;
    localparam logic [11:0] USP_OFFSET       = 12'h008;
    localparam logic [11:0] ACTIVE_SP_OFFSET = 12'h00c;
    localparam logic [11:0] ACK_INFO_OFFSET  = 12'h010;
    localparam logic [11:0] BANK_BASE        = 12'h040;
    localparam logic [11:0] BANK_REGION_MASK = 12'hfc0;
    localparam int unsigned BANK_SEL_ADDR_BIT = 5;

    // flag word field positions
    localparam int unsigned BANK_SEL_BIT  = 0;
    localparam int unsigned IRQ_EN_BIT    = 1;
    localparam int unsigned STACK_SEL_BIT = 2;
    localparam int unsigned RESERVED_BIT  = 3;
    localparam int unsigned PPL_LSB       = 4;

    // reset values
    localparam logic              IRQ_EN_RST    = 1'b0;
    localparam logic              STACK_SEL_RST = 1'b0;
    localparam logic              BANK_SEL_RST  = 1'b0;
    localparam logic [PRIO_W-1:0] PPL_RST       = 3'h0;

    // highest trap vector that forces the interrupt stack
    localparam logic [VEC_W-1:0] TRAP_ISP_MAX = 6'h1f;

    typedef struct packed {
        logic              bank_sel;
        logic              irq_enable;
        logic              stack_sel;
        logic [PRIO_W-1:0] processor_priority_level;
    } cfi_flags_t;

    typedef struct packed {
        logic              valid;
        logic [PRIO_W-1:0] prio;
    } cfi_irq_req_t;

    typedef struct packed {
        logic             boundary;
        logic             trap_exec;
        logic [VEC_W-1:0] trap_vec;
    } cfi_seq_t;

    typedef enum logic [1:0] {
        CFI_BUS_IDLE = 2'b01,
        CFI_BUS_RESP = 2'b10
    } cfi_bus_state_t;

endpackage

// ===== verilog/cfi_flag_accept.sv
// flag register, interrupt acceptance, stack select and banked registers of a 16-bit cpu core
// assumes apb master on sys_clk, request and sequencer inputs synchronous to sys_clk
//
// What this block does
// - Two full copies of the banked set exist, each with four general, two address and one frame base register.
// - Maskable requests are blocked while the interrupt enable flag is 0 and considered while it is 1.
// - Every acknowledged interrupt clears the interrupt enable flag to 0.
// - The stack-select flag picks the interrupt stack pointer at 0 and the user stack pointer at 1.
// - The stack-select flag clears on a hardware acknowledge and on a trap with vector 0 to 31.
// - The processor priority level is a 3-bit field with levels 0 through 7.
// - A request passes only when its priority is strictly above the processor priority level.
// - Software writes 0 to the reserved flag bit and must not rely on its read value.
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/10ps

module cfi_flag_accept #(
    parameter int unsigned REG_W = 16
) (
    // clock and reset
    input  wire logic                           sys_clk,
    input  wire logic                           rst,
    // apb slave
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [cfi_pkg::ADDR_W-1:0]     paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    // interrupt request source
    input  wire cfi_pkg::cfi_irq_req_t          irq_req,
    // instruction sequencer
    input  wire cfi_pkg::cfi_seq_t              seq,
    output logic                                irq_ack,
    output logic      [cfi_pkg::PRIO_W-1:0]     irq_ack_prio,
    output logic                                trap_ack,
    // processor state to the core
    output cfi_pkg::cfi_flags_t                 flags,
    output logic      [REG_W-1:0]               active_sp
);

    if (REG_W < 8 || REG_W > 32)
    begin : g_bad_width
        $error("cfi_flag_accept: REG_W must lie in 8..32");
    end

    // state
    cfi_pkg::cfi_bus_state_t               bus_st_q, bus_st_d;
    logic [31:0]                           prdata_q, prdata_d;
    logic                                  pready_q, pready_d;
    logic                                  pslverr_q, pslverr_d;
    cfi_pkg::cfi_flags_t                   flags_q, flags_d;
    logic [REG_W-1:0]                      isp_q, isp_d;
    logic [REG_W-1:0]                      usp_q, usp_d;
    logic [REG_W-1:0]                      sp_q, sp_d;
    logic                                  ack_q, ack_d;
    logic [cfi_pkg::PRIO_W-1:0]            ack_prio_q, ack_prio_d;
    logic                                  trap_ack_q, trap_ack_d;
    logic [REG_W-1:0]                      bank_q [cfi_pkg::NUM_BANKS][cfi_pkg::BANK_REGS];

    // decode
    logic                                  setup;
    logic                                  wr_done;
    logic                                  hit_flags;
    logic                                  hit_isp;
    logic                                  hit_usp;
    logic                                  hit_sp;
    logic                                  hit_ack;
    logic                                  hit_bank;
    logic                                  bank_addr;
    logic [2:0]                            bank_idx;
    logic                                  hw_ack;

    assign setup     = psel & ~penable;
    assign wr_done   = psel & penable & pready_q & pwrite & ~pslverr_q;
    assign bank_addr = paddr[cfi_pkg::BANK_SEL_ADDR_BIT];
    assign bank_idx  = paddr[4:2];

    always_comb
    begin
        hit_flags = 1'b0;
        hit_isp   = 1'b0;
        hit_usp   = 1'b0;
        hit_sp    = 1'b0;
        hit_ack   = 1'b0;
        hit_bank  = 1'b0;
        if (paddr == cfi_pkg::FLAGS_OFFSET)
            hit_flags = 1'b1;
        else if (paddr == cfi_pkg::ISP_OFFSET)
            hit_isp = 1'b1;
        else if (paddr == cfi_pkg::USP_OFFSET)
            hit_usp = 1'b1;
        else if (paddr == cfi_pkg::ACTIVE_SP_OFFSET)
            hit_sp = 1'b1;
        else if (paddr == cfi_pkg::ACK_INFO_OFFSET)
            hit_ack = 1'b1;
        else if ((paddr & cfi_pkg::BANK_REGION_MASK) == cfi_pkg::BANK_BASE && paddr[1:0] == 2'h0
                 && {29'h0000_0000, bank_idx} < cfi_pkg::BANK_REGS)
            hit_bank = 1'b1;
    end

    // acceptance: enable and strict priority, only at a boundary, and a trap in flight takes the slot
    assign hw_ack = seq.boundary & ~seq.trap_exec & irq_req.valid
                    & flags_q.irq_enable
                    & (irq_req.prio > flags_q.processor_priority_level);

    // apb answer: data prepared in setup, pready high in the single access cycle
    always_comb
    begin
        bus_st_d  = bus_st_q;
        prdata_d  = prdata_q;
        pready_d  = 1'b0;
        pslverr_d = 1'b0;
        case (bus_st_q)
            cfi_pkg::CFI_BUS_IDLE:
            begin
                if (setup)
                begin
                    bus_st_d  = cfi_pkg::CFI_BUS_RESP;
                    pready_d  = 1'b1;
                    pslverr_d = ~(hit_flags | hit_isp | hit_usp | hit_sp | hit_ack | hit_bank);
                    prdata_d  = 32'h0000_0000;
                    if (!pwrite)
                    begin
                        if (hit_flags)
                        begin
                            // reserved bit reads back as zero
                            prdata_d[cfi_pkg::BANK_SEL_BIT]  = flags_q.bank_sel;
                            prdata_d[cfi_pkg::IRQ_EN_BIT]    = flags_q.irq_enable;
                            prdata_d[cfi_pkg::STACK_SEL_BIT] = flags_q.stack_sel;
                            prdata_d[cfi_pkg::PPL_LSB +: cfi_pkg::PRIO_W] = flags_q.processor_priority_level;
                        end
                        else if (hit_isp)
                            prdata_d[REG_W-1:0] = isp_q;
                        else if (hit_usp)
                            prdata_d[REG_W-1:0] = usp_q;
                        else if (hit_sp)
                            prdata_d[REG_W-1:0] = sp_q;
                        else if (hit_ack)
                            prdata_d[cfi_pkg::PRIO_W-1:0] = ack_prio_q;
                        else if (hit_bank)
                            prdata_d[REG_W-1:0] = bank_q[bank_addr][bank_idx];
                    end
                end
            end
            cfi_pkg::CFI_BUS_RESP:
            begin
                bus_st_d = cfi_pkg::CFI_BUS_IDLE;
            end
            default:
            begin
                bus_st_d = cfi_pkg::CFI_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            bus_st_q  <= cfi_pkg::CFI_BUS_IDLE;
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            bus_st_q  <= bus_st_d;
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // flags and stack pointers; an acknowledge overrides a software write of enable, stack select and level in the same cycle
    always_comb
    begin
        flags_d    = flags_q;
        isp_d      = isp_q;
        usp_d      = usp_q;
        ack_d      = hw_ack;
        trap_ack_d = seq.trap_exec;
        ack_prio_d = ack_prio_q;
        if (wr_done && hit_flags)
        begin
            // reserved bit is dropped on write
            flags_d.bank_sel   = pwdata[cfi_pkg::BANK_SEL_BIT];
            flags_d.irq_enable = pwdata[cfi_pkg::IRQ_EN_BIT];
            flags_d.stack_sel  = pwdata[cfi_pkg::STACK_SEL_BIT];
            flags_d.processor_priority_level = pwdata[cfi_pkg::PPL_LSB +: cfi_pkg::PRIO_W];
        end
        if (wr_done && hit_isp)
            isp_d = pwdata[REG_W-1:0];
        if (wr_done && hit_usp)
            usp_d = pwdata[REG_W-1:0];
        if (hw_ack)
        begin
            flags_d.irq_enable = 1'b0;
            flags_d.stack_sel  = 1'b0;
            flags_d.processor_priority_level = irq_req.prio;
            ack_prio_d = irq_req.prio;
        end
        else if (seq.trap_exec)
        begin
            flags_d.irq_enable = 1'b0;
            if (seq.trap_vec <= cfi_pkg::TRAP_ISP_MAX)
                flags_d.stack_sel = 1'b0;
        end
        // follows the updated flag so the core never sees a stale pointer
        sp_d = flags_d.stack_sel ? usp_d : isp_d;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            flags_q.bank_sel   <= cfi_pkg::BANK_SEL_RST;
            flags_q.irq_enable <= cfi_pkg::IRQ_EN_RST;
            flags_q.stack_sel  <= cfi_pkg::STACK_SEL_RST;
            flags_q.processor_priority_level <= cfi_pkg::PPL_RST;
            isp_q      <= '0;
            usp_q      <= '0;
            sp_q       <= '0;
            ack_q      <= 1'b0;
            ack_prio_q <= cfi_pkg::PPL_RST;
            trap_ack_q <= 1'b0;
        end
        else
        begin
            flags_q    <= flags_d;
            isp_q      <= isp_d;
            usp_q      <= usp_d;
            sp_q       <= sp_d;
            ack_q      <= ack_d;
            ack_prio_q <= ack_prio_d;
            trap_ack_q <= trap_ack_d;
        end
    end

    // banked set: two copies, selected by address, only software loads them here
    for (genvar b = 0; b < cfi_pkg::NUM_BANKS; b++)
    begin : g_bank
        for (genvar r = 0; r < cfi_pkg::BANK_REGS; r++)
        begin : g_reg
            logic [REG_W-1:0] reg_d;
            always_comb
            begin
                reg_d = bank_q[b][r];
                if (wr_done && hit_bank && bank_addr == b[0] && bank_idx == r[2:0])
                    reg_d = pwdata[REG_W-1:0];
            end
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                    bank_q[b][r] <= '0;
                else
                    bank_q[b][r] <= reg_d;
            end
        end
    end

    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign irq_ack      = ack_q;
    assign irq_ack_prio = ack_prio_q;
    assign trap_ack     = trap_ack_q;
    assign flags        = flags_q;
    assign active_sp    = sp_q;

endmodule

// ===== test/cfi_flag_accept_asserts.sv
// checker for the flag and interrupt-accept block
// assumes a bind onto cfi_flag_accept, one clock domain
`timescale 1ns/10ps
module cfi_flag_accept_asserts #(
    parameter int unsigned REG_W = 16
) (
    // clock, reset, bus
    input wire logic                       sys_clk,
    input wire logic                       rst,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pready,
    // requests and sequencer
    input wire cfi_pkg::cfi_irq_req_t      irq_req,
    input wire cfi_pkg::cfi_seq_t          seq,
    input wire logic                       irq_ack,
    input wire logic [cfi_pkg::PRIO_W-1:0] irq_ack_prio,
    input wire logic                       trap_ack,
    input wire cfi_pkg::cfi_flags_t        flags
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_take;
        seq.boundary && !seq.trap_exec && irq_req.valid && flags.irq_enable
            && irq_req.prio > flags.processor_priority_level;
    endsequence
    sequence s_low;
        seq.boundary && irq_req.valid && irq_req.prio <= flags.processor_priority_level;
    endsequence
    property p_take; s_take |=> irq_ack && irq_ack_prio == $past(irq_req.prio); endproperty
    property p_low; s_low |=> !irq_ack; endproperty
    property p_off; irq_ack |-> $past(flags.irq_enable); endproperty
    property p_ie; irq_ack || trap_ack |-> !flags.irq_enable; endproperty
    property p_hw_ss; irq_ack |-> !flags.stack_sel; endproperty
    property p_trap_lo; seq.trap_exec && seq.trap_vec <= 6'h1f |=> trap_ack && !flags.stack_sel; endproperty
    // a bus write in the same cycle could move the flag legally
    property p_trap_hi; seq.trap_exec && seq.trap_vec > 6'h1f && !psel |=> $stable(flags.stack_sel); endproperty
    property p_ppl;
        irq_ack |-> flags.processor_priority_level == irq_ack_prio
            && irq_ack_prio > $past(flags.processor_priority_level);
    endproperty
    property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
    a_take: assert property (p_take) else $error("request not accepted");
    a_low: assert property (p_low) else $error("low request accepted");
    a_off: assert property (p_off) else $error("accept while disabled");
    a_ie: assert property (p_ie) else $error("enable not cleared");
    a_hw_ss: assert property (p_hw_ss) else $error("stack select kept");
    a_trap_lo: assert property (p_trap_lo) else $error("low trap wrong");
    a_trap_hi: assert property (p_trap_hi) else $error("high trap moved stack");
    a_ppl: assert property (p_ppl) else $error("level not loaded");
    a_rdy: assert property (p_rdy) else $error("ready timing");
endmodule
bind cfi_flag_accept cfi_flag_accept_asserts #(.REG_W(REG_W)) u_chk (.sys_clk, .rst, .psel, .penable,
    .pready, .irq_req, .seq, .irq_ack, .irq_ack_prio, .trap_ack, .flags);

// ===== test/cfi_src_model.sv
// model of the request source and the instruction sequencer
// assumes bench commands change just after rising edges
`timescale 1ns/10ps
module cfi_src_model (
    // clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       rst,
    // bench commands
    input  wire logic                       req_set,
    input  wire logic                       req_clr,
    input  wire logic [cfi_pkg::PRIO_W-1:0] req_prio,
    input  wire logic                       slow,
    input  wire logic                       trap_go,
    input  wire logic [cfi_pkg::VEC_W-1:0]  trap_vec,
    // block side
    input  wire logic                       irq_ack,
    output cfi_pkg::cfi_irq_req_t           irq_req,
    output cfi_pkg::cfi_seq_t               seq
);
    logic [1:0] gap_q;
    always_ff @(posedge sys_clk)
    begin
        gap_q <= rst ? 2'h0 : gap_q + 2'h1;
        // slow mode spaces boundaries four cycles apart
        seq.boundary <= !rst && (!slow || gap_q == 2'h3);
        seq.trap_exec <= !rst && trap_go;
        // vector not held outside its pulse
        seq.trap_vec <= trap_go ? trap_vec : ~seq.trap_vec;
        // request held until accepted or cleared by req_clr
        if (rst || irq_ack || req_clr)
            irq_req.valid <= 1'b0;
        else if (req_set)
            irq_req.valid <= 1'b1;
        if (req_set)
            irq_req.prio <= req_prio;
    end
endmodule

// ===== test/cfi_flag_accept_bench.sv
// self-checking bench for the flag and interrupt-accept block
// assumes the source model and the bound checker
`timescale 1ns/10ps
`define CHK(a, b, m) begin n_tests++; if ((a) !== (b)) begin n_errors++; $display("wrong value at %0t: %s", $time, m); end end
module cfi_flag_accept_bench;
    logic                  sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0]           paddr = 12'h000;
    logic [31:0]           pwdata = 32'h0000_0000, prdata, rd;
    logic                  pready, pslverr, irq_ack, trap_ack, en, er, got;
    logic                  req_set = 1'b0, req_clr = 1'b0, slow = 1'b0, trap_go = 1'b0;
    logic [2:0]            irq_ack_prio, p, q, req_prio = 3'h0;
    logic [5:0]            trap_vec = 6'h00;
    logic [5:0]            vv [4] = '{6'h1f, 6'h20, 6'h00, 6'h3f};
    logic [15:0]           active_sp, isp_v, usp_v;
    logic [15:0]           bw [16];
    cfi_pkg::cfi_irq_req_t irq_req;
    cfi_pkg::cfi_seq_t     seq;
    cfi_pkg::cfi_flags_t   flags;
    int                    n_errors = 0, n_tests = 0, cyc = 0;
    initial forever #2.5 sys_clk = ~sys_clk;
    cfi_flag_accept uut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .irq_req, .seq, .irq_ack, .irq_ack_prio, .trap_ack, .flags, .active_sp);
    cfi_src_model u_src (.sys_clk, .rst, .req_set, .req_clr, .req_prio, .slow, .trap_go, .trap_vec,
        .irq_ack, .irq_req, .seq);
    function automatic logic [31:0] flw(input logic e, input logic s, input logic [2:0] l);
        return {25'h000_0000, l, 1'b0, s, e, 1'b0};
    endfunction
    function automatic logic want(input logic e, input logic [2:0] l, input logic [2:0] r);
        return e && r > l;
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ceiling well above the several hundred cycles the run needs
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            print_verdict();
        end
    end
    initial
    begin
        void'($urandom(32'h0a89cccf));
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        apb(0, cfi_pkg::FLAGS_OFFSET, 0);
        `CHK(rd, 32'h0000_0000, "flags reset")
        apb(1, cfi_pkg::FLAGS_OFFSET, 32'h0000_0077);
        apb(0, cfi_pkg::FLAGS_OFFSET, 0);
        `CHK(rd & 32'hffff_fff7, 32'h0000_0077, "flags rw")
        isp_v = 16'($urandom);
        usp_v = 16'($urandom);
        apb(1, cfi_pkg::ISP_OFFSET, {16'h0000, isp_v});
        apb(1, cfi_pkg::USP_OFFSET, {16'h0000, usp_v});
        for (int s = 0; s < 2; s++)
        begin
            apb(1, cfi_pkg::FLAGS_OFFSET, flw(0, s[0], 0));
            apb(0, cfi_pkg::ACTIVE_SP_OFFSET, 0);
            `CHK(rd[15:0], s ? usp_v : isp_v, "stack pointer read")
            `CHK(active_sp, s ? usp_v : isp_v, "stack pointer port")
        end
        for (int k = 0; k < 16; k++)
        begin
            bw[k] = 16'($urandom);
            apb(1, cfi_pkg::BANK_BASE + 12'(k * 4), {16'h0000, bw[k]});
        end
        for (int k = 0; k < 16; k++)
        begin
            apb(0, cfi_pkg::BANK_BASE + 12'(k * 4), 0);
            `CHK(rd, k % 8 == 7 ? 32'h0000_0000 : {16'h0000, bw[k]}, "bank word")
            `CHK(er, k % 8 == 7, "bank error")
        end
        for (int n = 0; n < 24; n++)
        begin
            p = 3'($urandom);
            q = n % 3 == 0 ? p : 3'($urandom);
            en = n % 4 != 1;
            slow <= n[0];
            apb(1, cfi_pkg::FLAGS_OFFSET, flw(en, 1, p));
            req_prio <= q;
            req_set <= 1'b1;
            @(posedge sys_clk);
            req_set <= 1'b0;
            got = 1'b0;
            repeat (8)
            begin
                @(posedge sys_clk);
                got |= irq_ack;
            end
            `CHK(got, want(en, p, q), "acceptance")
            apb(0, cfi_pkg::FLAGS_OFFSET, 0);
            `CHK(rd, flw(en && !got, !got, got ? q : p), "flags after request")
            `CHK(flags, {1'b0, en && !got, !got, got ? q : p}, "flags port")
            if (got)
            begin
                `CHK(irq_ack_prio, q, "ack priority")
                apb(0, cfi_pkg::ACK_INFO_OFFSET, 0);
                `CHK(rd, {29'h0000_0000, q}, "ack info")
            end
            req_clr <= 1'b1;
            @(posedge sys_clk);
            req_clr <= 1'b0;
        end
        foreach (vv[j])
        begin
            apb(1, cfi_pkg::FLAGS_OFFSET, flw(1, 1, 3));
            trap_vec <= vv[j];
            trap_go <= 1'b1;
            @(posedge sys_clk);
            trap_go <= 1'b0;
            @(posedge sys_clk);
            @(posedge sys_clk);
            `CHK(trap_ack, 1'b1, "trap ack")
            apb(0, cfi_pkg::FLAGS_OFFSET, 0);
            `CHK(rd, flw(0, vv[j] > 6'h1f, 3), "trap flags")
        end
        // mid-run reset must bring every flag and pointer back to zero
        apb(1, cfi_pkg::FLAGS_OFFSET, flw(1, 1, 5));
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        `CHK(flags, 6'h00, "flags after reset")
        apb(0, cfi_pkg::ACTIVE_SP_OFFSET, 0);
        `CHK(rd, 32'h0000_0000, "sp after reset")
        print_verdict();
    end
endmodule
